/* File: hw/ioscm_pkg.sv */
/*
 * constants and types shared by the internal oscillator and clock multiplier block.
 * assumes a 100 MHz register clock and 8-bit registers packed one per AXI4-Lite word.
 */
package ioscm_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_FINE = 8'h9E;
	localparam logic [7:0] IDX_CTRL = 8'hA1;
	localparam logic [7:0] IDX_COARSE = 8'hA2;
	localparam logic [7:0] IDX_MUL = 8'h97;
	localparam logic [7:0] IDX_SYS_CLOCK_SOURCE_REG = 8'h8F;
	localparam int ADDR_W = 12;

	// internal_osc_control fields
	localparam int CTRL_EN_HI = 7;
	localparam int CTRL_EN_LO = 6;
	localparam int CTRL_SUSP_BIT = 5;
	localparam int CTRL_FRDY_BIT = 4;
	localparam int CTRL_DIV_HI = 2;
	// multiplier_control fields
	localparam int MUL_EN_BIT = 7;
	localparam int MUL_INIT_BIT = 6;
	localparam int MUL_DIV_HI = 4;
	localparam int MUL_DIV_LO = 2;
	localparam int MUL_SEL_HI = 1;

	// reset values; trims stand in for factory values giving 24 MHz
	localparam logic [1:0] OSC_EN_ON = 2'h3;
	localparam logic [6:0] CRS_RST = 7'h40;
	localparam logic [5:0] FIN_RST = 6'h20;

	// system clock source codes
	localparam logic [1:0] SRC_OSC = 2'h0;
	localparam logic [1:0] SRC_EXT = 2'h1;
	localparam logic [1:0] SRC_MUL = 2'h2;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int LOCK_TIME_NS = 2000;
	localparam logic [8:0] LOCK_CYC = 9'((LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [9:0] OSC_SLOW_CYC = 10'h258;
	localparam logic [9:0] OSC_CRS_STEP = 10'h004;
	localparam int OSC_FIN_SHIFT = 3;
	localparam logic [2:0] FRDY_SETTLE = 3'h4;
	localparam logic [1:0] MUL_GAP_CYC = 2'h2;
	localparam logic [2:0] BURST_X2 = 3'h2;
	localparam logic [2:0] BURST_X4 = 3'h4;

	typedef enum logic [1:0] {MUL_OFF, MUL_ARMED, MUL_LOCKING, MUL_READY} ioscm_mul_state_t;
	typedef enum logic [2:0] {RS_NONE, RS_FINE, RS_CTRL, RS_COARSE, RS_MUL, RS_SYS_CLOCK_SOURCE_REG} ioscm_reg_t;
endpackage

/* File: hw/ioscm_clk_div.sv */
/*
 * power-of-two divider of the oscillator tick into system clock ticks.
 * assumes tickIn is a one-cycle pulse; a new divider code is taken only at a period end.
 */
`timescale 1ns/1ps
`default_nettype none
module ioscm_clk_div (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic tickIn,
	input wire logic [2:0] divSel,
	output logic tickOut
);
	typedef struct packed {
		logic [6:0] cnt;
		logic [2:0] sel;
		logic out;
	} ioscm_div_state_t;

	ioscm_div_state_t st_ff;
	ioscm_div_state_t nxt_st;

	// code 000 divides by 128, each step halves it, 111 passes every tick
	function automatic logic [6:0] divLast(input logic [2:0] sel);
		divLast = 7'((8'h80 >> sel) - 8'h01);
	endfunction

	always_comb begin
		nxt_st = st_ff;
		nxt_st.out = 1'b0;
		if (tickIn) begin
			if (st_ff.cnt >= divLast(st_ff.sel)) begin
				nxt_st.out = 1'b1;
				nxt_st.cnt = 7'h00;
				// switching only at the wrap keeps every output period whole
				nxt_st.sel = divSel;
			end else begin
				nxt_st.cnt = st_ff.cnt + 7'h01;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign tickOut = st_ff.out;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_div_switch_edge: assert property ($changed(st_ff.sel) |-> st_ff.out)
		else $error("divider setting changed mid period");
	a_div_by_one: assert property (st_ff.sel == 3'h7 && tickIn |=> st_ff.out)
		else $error("divide by one missed a tick");
	c_div_change: cover property ($changed(st_ff.sel));
endmodule
`default_nettype wire

/* File: hw/ioscm_top.sv */
/*
 * internal oscillator control, trims, system clock divider and clock multiplier model,
 * with AXI4-Lite register access. all clocks are modelled as one-cycle tick enables on mclk.
 * assumes extOscTick, portMatch and comparator inputs are synchronous to mclk.
 */
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ioscm_top (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic extOscTick,
	input wire logic [3:0] portMatch,
	input wire logic cmp0En,
	input wire logic cmp0Out,
	output logic sysClkTick,
	output logic intOscTick,
	output logic multClkTick
);
	typedef struct packed {
		logic awHeld;
		logic [11:0] awAddr;
		logic wHeld;
		logic [7:0] wByte;
		logic wStrb0;
		logic awReady;
		logic wReady;
		logic bValid;
		logic [1:0] bResp;
		logic arReady;
		logic rValid;
		logic [7:0] rByte;
		logic [1:0] rResp;
		logic rCtrl;
		logic [1:0] oscEn;
		logic susp;
		logic [2:0] ifDiv;
		logic frdy;
		logic [2:0] settle;
		logic [9:0] oscCnt;
		logic oscTick;
		logic [6:0] crs;
		logic [5:0] fin;
		logic mult_enable_bit;
		logic mult_init_bit;
		logic [2:0] mult_output_scale;
		logic [1:0] mult_input_select;
		ioscm_pkg::ioscm_mul_state_t mulState;
		logic [8:0] lockCnt;
		logic [2:0] burstLeft;
		logic [1:0] gapCnt;
		logic [3:0] acc;
		logic mulTick;
		logic [1:0] src;
		logic sysTick;
	} ioscm_state_t;

	localparam ioscm_state_t ST_RST = '{
		oscEn: ioscm_pkg::OSC_EN_ON,
		crs: ioscm_pkg::CRS_RST,
		fin: ioscm_pkg::FIN_RST,
		awReady: 1'b1,
		wReady: 1'b1,
		arReady: 1'b1,
		mulState: ioscm_pkg::MUL_OFF,
		default: '0
	};

	ioscm_state_t st_ff;
	ioscm_state_t nxt_st;
	logic divTick;
	logic oscRun;
	logic wrGo;
	logic wake;
	logic inTick;

	function automatic ioscm_pkg::ioscm_reg_t regSel(input logic [11:0] addr);
		if (addr == {2'b00, ioscm_pkg::IDX_FINE, 2'b00})
			regSel = ioscm_pkg::RS_FINE;
		else if (addr == {2'b00, ioscm_pkg::IDX_CTRL, 2'b00})
			regSel = ioscm_pkg::RS_CTRL;
		else if (addr == {2'b00, ioscm_pkg::IDX_COARSE, 2'b00})
			regSel = ioscm_pkg::RS_COARSE;
		else if (addr == {2'b00, ioscm_pkg::IDX_MUL, 2'b00})
			regSel = ioscm_pkg::RS_MUL;
		else if (addr == {2'b00, ioscm_pkg::IDX_SYS_CLOCK_SOURCE_REG, 2'b00})
			regSel = ioscm_pkg::RS_SYS_CLOCK_SOURCE_REG;
		else
			regSel = ioscm_pkg::RS_NONE;
	endfunction

	// larger trim codes give a shorter period, fine on top of coarse
	function automatic logic [9:0] oscPeriod(input logic [6:0] crs, input logic [5:0] fin);
		oscPeriod = ioscm_pkg::OSC_SLOW_CYC - 10'({3'h0, crs} * ioscm_pkg::OSC_CRS_STEP)
			- 10'(fin >> ioscm_pkg::OSC_FIN_SHIFT);
	endfunction

	// scaling 2/k: a pulse passes each time the accumulator reaches k
	function automatic logic [3:0] mulDen(input logic [1:0] sel, input logic [2:0] div);
		if (!sel[ioscm_pkg::MUL_SEL_HI])
			mulDen = 4'h2;
		else begin
			case (div)
				3'h3: mulDen = 4'h3;
				3'h4: mulDen = 4'h4;
				3'h5: mulDen = 4'h5;
				3'h6: mulDen = 4'h6;
				3'h7: mulDen = 4'h7;
				default: mulDen = 4'h2;
			endcase
		end
	endfunction

	ioscm_clk_div u_div (
		.mclk(mclk),
		.rst_n(rst_n),
		.tickIn(st_ff.oscTick),
		.divSel(st_ff.ifDiv),
		.tickOut(divTick)
	);

	assign oscRun = st_ff.oscEn == ioscm_pkg::OSC_EN_ON && !st_ff.susp;
	assign wrGo = st_ff.awHeld && st_ff.wHeld && !st_ff.bValid;
	assign wake = (|portMatch) || (cmp0En && !cmp0Out);
	assign inTick = st_ff.mult_input_select[0] ? extOscTick : st_ff.oscTick;

	always_comb begin
		ioscm_pkg::ioscm_reg_t wSel;
		ioscm_pkg::ioscm_reg_t rSel;
		logic [3:0] sum;
		wSel = regSel(st_ff.awAddr);
		rSel = regSel(araddr);
		sum = 4'h0;
		nxt_st = st_ff;
		nxt_st.oscTick = 1'b0;
		nxt_st.mulTick = 1'b0;
		nxt_st.sysTick = 1'b0;

		if (awvalid && st_ff.awReady) begin
			nxt_st.awHeld = 1'b1;
			nxt_st.awAddr = awaddr;
		end
		if (wvalid && st_ff.wReady) begin
			nxt_st.wHeld = 1'b1;
			nxt_st.wByte = wdata[7:0];
			nxt_st.wStrb0 = wstrb[0];
		end
		if (bready && st_ff.bValid)
			nxt_st.bValid = 1'b0;

		if (st_ff.susp && wake)
			nxt_st.susp = 1'b0;

		// a suspend write in the wake cycle still suspends: software asked last
		if (wrGo) begin
			nxt_st.awHeld = 1'b0;
			nxt_st.wHeld = 1'b0;
			nxt_st.bValid = 1'b1;
			nxt_st.bResp = (wSel == ioscm_pkg::RS_NONE) ? ioscm_pkg::RESP_DECERR
				: ioscm_pkg::RESP_OKAY;
			if (st_ff.wStrb0) begin
				case (wSel)
					ioscm_pkg::RS_CTRL: begin
						nxt_st.oscEn = st_ff.wByte[ioscm_pkg::CTRL_EN_HI:ioscm_pkg::CTRL_EN_LO];
						if (st_ff.wByte[ioscm_pkg::CTRL_SUSP_BIT])
							nxt_st.susp = 1'b1;
						nxt_st.ifDiv = st_ff.wByte[ioscm_pkg::CTRL_DIV_HI:0];
					end
					ioscm_pkg::RS_COARSE: nxt_st.crs = st_ff.wByte[6:0];
					ioscm_pkg::RS_FINE: nxt_st.fin = st_ff.wByte[5:0];
					ioscm_pkg::RS_MUL: begin
						nxt_st.mult_enable_bit = st_ff.wByte[ioscm_pkg::MUL_EN_BIT];
						nxt_st.mult_init_bit = st_ff.wByte[ioscm_pkg::MUL_INIT_BIT]
							&& st_ff.wByte[ioscm_pkg::MUL_EN_BIT];
						nxt_st.mult_output_scale = st_ff.wByte[ioscm_pkg::MUL_DIV_HI:ioscm_pkg::MUL_DIV_LO];
						nxt_st.mult_input_select = st_ff.wByte[ioscm_pkg::MUL_SEL_HI:0];
					end
					ioscm_pkg::RS_SYS_CLOCK_SOURCE_REG: nxt_st.src = st_ff.wByte[1:0];
					default: begin
					end
				endcase
			end
		end

		if (rready && st_ff.rValid)
			nxt_st.rValid = 1'b0;
		if (arvalid && st_ff.arReady) begin
			nxt_st.rValid = 1'b1;
			nxt_st.rCtrl = rSel == ioscm_pkg::RS_CTRL;
			nxt_st.rResp = (rSel == ioscm_pkg::RS_NONE) ? ioscm_pkg::RESP_DECERR
				: ioscm_pkg::RESP_OKAY;
			case (rSel)
				ioscm_pkg::RS_CTRL: nxt_st.rByte = {st_ff.oscEn, st_ff.susp, st_ff.frdy,
					1'b0, st_ff.ifDiv};
				ioscm_pkg::RS_COARSE: nxt_st.rByte = {1'b0, st_ff.crs};
				ioscm_pkg::RS_FINE: nxt_st.rByte = {2'b00, st_ff.fin};
				ioscm_pkg::RS_MUL: nxt_st.rByte = {st_ff.mult_enable_bit, st_ff.mult_init_bit,
					st_ff.mulState == ioscm_pkg::MUL_READY, st_ff.mult_output_scale, st_ff.mult_input_select};
				ioscm_pkg::RS_SYS_CLOCK_SOURCE_REG: nxt_st.rByte = {6'h00, st_ff.src};
				default: nxt_st.rByte = 8'h00;
			endcase
		end
		nxt_st.awReady = !nxt_st.awHeld && !nxt_st.bValid;
		nxt_st.wReady = !nxt_st.wHeld && !nxt_st.bValid;
		nxt_st.arReady = !nxt_st.rValid;

		// oscillator: ready only after a few whole periods at the programmed trim
		if (!oscRun) begin
			nxt_st.oscCnt = 10'h000;
			nxt_st.frdy = 1'b0;
			nxt_st.settle = 3'h0;
		end else if (st_ff.oscCnt == 10'h000) begin
			nxt_st.oscTick = 1'b1;
			nxt_st.oscCnt = oscPeriod(st_ff.crs, st_ff.fin);
			if (st_ff.settle == ioscm_pkg::FRDY_SETTLE)
				nxt_st.frdy = 1'b1;
			else
				nxt_st.settle = st_ff.settle + 3'h1;
		end else begin
			nxt_st.oscCnt = st_ff.oscCnt - 10'h001;
		end

		case (st_ff.mulState)
			ioscm_pkg::MUL_OFF:
				if (st_ff.mult_enable_bit)
					nxt_st.mulState = ioscm_pkg::MUL_ARMED;
			ioscm_pkg::MUL_ARMED:
				if (st_ff.mult_init_bit) begin
					nxt_st.mulState = ioscm_pkg::MUL_LOCKING;
					nxt_st.lockCnt = ioscm_pkg::LOCK_CYC;
				end
			ioscm_pkg::MUL_LOCKING:
				if (st_ff.lockCnt <= 9'h001)
					nxt_st.mulState = ioscm_pkg::MUL_READY;
				else
					nxt_st.lockCnt = st_ff.lockCnt - 9'h001;
			ioscm_pkg::MUL_READY: begin
			end
			default: nxt_st.mulState = ioscm_pkg::MUL_OFF;
		endcase

		// each input edge starts a burst of 4 (or 2) fast pulses, then idles; a new
		// edge during a burst restarts it, so over-fast inputs lose pulses
		if (st_ff.mulState == ioscm_pkg::MUL_READY && inTick) begin
			nxt_st.burstLeft = st_ff.mult_input_select[ioscm_pkg::MUL_SEL_HI] ? ioscm_pkg::BURST_X4
				: ioscm_pkg::BURST_X2;
			nxt_st.gapCnt = 2'h0;
		end else if (st_ff.burstLeft != 3'h0) begin
			if (st_ff.gapCnt == 2'h0) begin
				nxt_st.burstLeft = st_ff.burstLeft - 3'h1;
				nxt_st.gapCnt = ioscm_pkg::MUL_GAP_CYC - 2'h1;
				sum = st_ff.acc + 4'h2;
				if (sum >= mulDen(st_ff.mult_input_select, st_ff.mult_output_scale)) begin
					nxt_st.mulTick = 1'b1;
					nxt_st.acc = sum - mulDen(st_ff.mult_input_select, st_ff.mult_output_scale);
				end else begin
					nxt_st.acc = sum;
				end
			end else begin
				nxt_st.gapCnt = st_ff.gapCnt - 2'h1;
			end
		end
		if (!st_ff.mult_enable_bit) begin
			nxt_st.mulState = ioscm_pkg::MUL_OFF;
			nxt_st.burstLeft = 3'h0;
			nxt_st.acc = 4'h0;
		end

		case (st_ff.src)
			ioscm_pkg::SRC_OSC: nxt_st.sysTick = divTick;
			ioscm_pkg::SRC_EXT: nxt_st.sysTick = extOscTick;
			ioscm_pkg::SRC_MUL: nxt_st.sysTick = st_ff.mulTick;
			default: nxt_st.sysTick = 1'b0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			st_ff <= ST_RST;
		else
			st_ff <= nxt_st;
	end

	assign awready = st_ff.awReady;
	assign wready = st_ff.wReady;
	assign bvalid = st_ff.bValid;
	assign bresp = st_ff.bResp;
	assign arready = st_ff.arReady;
	assign rvalid = st_ff.rValid;
	assign rresp = st_ff.rResp;
	assign rdata = {24'h000000, st_ff.rByte};
	assign intOscTick = st_ff.oscTick;
	assign multClkTick = st_ff.mulTick;
	assign sysClkTick = st_ff.sysTick;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_osc_enable_gate: assert property (st_ff.oscTick |-> $past(oscRun))
		else $error("oscillator ticked while disabled or suspended");
	a_suspend_wake: assert property (st_ff.susp && wake && !wrGo |=> !st_ff.susp)
		else $error("wake event did not end suspend");
	a_suspend_holds: assert property (st_ff.susp && !wake |=> st_ff.susp)
		else $error("suspend ended without a wake event");
	a_ready_flag: assert property (st_ff.frdy |-> $past(oscRun))
		else $error("frequency ready while oscillator stopped");
	a_reserved_zero: assert property (st_ff.rValid && st_ff.rCtrl |-> rdata[3] == 1'b0)
		else $error("reserved control bit read as one");
	a_mul_lock_path: assert property ($rose(st_ff.mulState == ioscm_pkg::MUL_READY)
		|-> $past(st_ff.mulState) == ioscm_pkg::MUL_LOCKING)
		else $error("multiplier ready without lock phase");
	a_burst_load: assert property (st_ff.mulState == ioscm_pkg::MUL_READY && st_ff.mult_enable_bit
		&& inTick |=> st_ff.burstLeft == ($past(st_ff.mult_input_select[1]) ? 3'h4 : 3'h2))
		else $error("burst length wrong for selected input");
	a_mul_tick_burst: assert property (st_ff.mulTick |-> $past(st_ff.burstLeft) != 3'h0)
		else $error("multiplier pulse outside a burst");
	a_mul_to_sys: assert property (st_ff.src == ioscm_pkg::SRC_MUL && st_ff.mulTick
		|=> st_ff.sysTick)
		else $error("multiplier pulse did not reach system clock");

	c_mul_ready: cover property ($rose(st_ff.mulState == ioscm_pkg::MUL_READY));
	c_wake: cover property (st_ff.susp ##1 !st_ff.susp);
	c_sys_from_mul: cover property (st_ff.src == ioscm_pkg::SRC_MUL && st_ff.sysTick);
	c_freq_ready: cover property ($rose(st_ff.frdy));
endmodule
`default_nettype wire

/* File: verif/test_internal_osc_and_clock_multiplier.sv */
/*
 bench for ioscm_top: AXI4-Lite register tasks, tick outputs timed in mclk cycles.
 assumes the fixed bus latencies and tick timing of ioscm_top, all in mclk cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module test_internal_osc_and_clock_multiplier;
	logic mclk = 1'h0, rst_n = 1'h0;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = 32'h0, d, rdata;
	logic [3:0] wstrb = 4'h0, portMatch = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, sysClkTick, intOscTick, multClkTick;
	logic [1:0] bresp, rresp;
	logic extOscTick = 1'h0, extOn = 1'h0, cmp0En = 1'h0, cmp0Out = 1'h1;
	int nFail = 0, nChecks = 0, c, p, i, j, k, extCnt = 0;
	int oscP;
	wire logic [3:0] ticks = {extOscTick, multClkTick, sysClkTick, intOscTick};

	ioscm_top dut (.mclk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .extOscTick, .portMatch, .cmp0En, .cmp0Out, .sysClkTick,
		.intOscTick, .multClkTick);

	always #5 mclk = ~mclk;

	// external source stands still unless a test turns it on
	always @(posedge mclk) begin
		extCnt <= (extCnt == 99) ? 0 : extCnt + 1;
		extOscTick <= extOn && extCnt == 0;
	end

	task results;
		$display("checks %0d mismatches %0d", nChecks, nFail);
		if (nFail == 0 && nChecks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task to;
		nFail++;
		$display("[ERR] %0t wait timed out", $time);
		results;
	endtask

	task check(input logic [31:0] got, input logic [31:0] exp, input string m);
		nChecks++;
		if (got !== exp) begin
			nFail++;
			$display("[ERR] %0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask

	function logic [11:0] ad(input logic [7:0] x);
		return {2'h0, x, 2'h0};
	endfunction

	function int per(input int crs, input int fin);
		return 601 - 4 * crs - fin / 8;
	endfunction

	task wr(input logic [7:0] x, input logic [7:0] v, input logic [3:0] s = 4'h1,
		input logic [1:0] e = ioscm_pkg::RESP_OKAY);
		int n;
		@(posedge mclk);
		awaddr <= ad(x);
		wdata <= {24'h0, v};
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (bvalid) break;
		end
		bready <= 1'h0;
		if (n == 50) to();
		check(32'(bresp), 32'(e), "bresp");
	endtask

	task rd(input logic [7:0] x, output logic [31:0] v, input logic [1:0] e = ioscm_pkg::RESP_OKAY);
		int n;
		@(posedge mclk);
		araddr <= ad(x);
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (arready) arvalid <= 1'h0;
			if (rvalid) break;
		end
		v = rdata;
		rready <= 1'h0;
		if (n == 50) to();
		check(32'(rresp), 32'(e), "rresp");
	endtask

	// cycles until the chosen tick is next seen high
	task gap(input int w, output int n);
		for (n = 1; n < 20000; n++) begin
			@(posedge mclk);
			if (ticks[w] === 1'h1) break;
		end
		if (n == 20000) to();
	endtask

	task cnt(input int w, input int len, output int n);
		n = 0;
		repeat (len) begin
			@(posedge mclk);
			if (ticks[w] === 1'h1) n++;
		end
	endtask

	task waitRdy;
		int n;
		for (n = 0; n < 100; n++) begin
			rd(ioscm_pkg::IDX_CTRL, d);
			if (d[4] === 1'h1) break;
			repeat (50) @(posedge mclk);
		end
		if (n == 100) to();
	endtask

	task mcfg(input logic [4:0] cfg);
		int n;
		wr(ioscm_pkg::IDX_MUL, 8'h00);
		rd(ioscm_pkg::IDX_MUL, d);
		check(d, 32'h0, "mul cleared");
		wr(ioscm_pkg::IDX_MUL, {3'h0, cfg});
		wr(ioscm_pkg::IDX_MUL, {3'h4, cfg});
		// more than 5 us at 10 ns per cycle
		repeat (600) @(posedge mclk);
		wr(ioscm_pkg::IDX_MUL, {3'h6, cfg});
		for (n = 0; n < 100; n++) begin
			rd(ioscm_pkg::IDX_MUL, d);
			if (d[5] === 1'h1) break;
			repeat (10) @(posedge mclk);
		end
		if (n == 100) to();
		check(d, {24'h0, 3'h7, cfg}, "mul ready");
	endtask

	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'h1;
		rd(ioscm_pkg::IDX_CTRL, d);
		check(d, 32'hC0, "ctrl reset");
		rd(ioscm_pkg::IDX_COARSE, d);
		check(d, 32'h40, "coarse reset");
		rd(ioscm_pkg::IDX_FINE, d);
		check(d, 32'h20, "fine reset");
		rd(ioscm_pkg::IDX_MUL, d);
		check(d, 32'h0, "mul reset");
		waitRdy();
		check(d, 32'hD0, "ready set");
		$display("test reset done");

		wr(ioscm_pkg::IDX_COARSE, 8'hFF);
		rd(ioscm_pkg::IDX_COARSE, d);
		check(d, 32'h7F, "coarse upper");
		wr(ioscm_pkg::IDX_FINE, 8'hFF);
		wr(ioscm_pkg::IDX_FINE, 8'h00, 4'h0);
		rd(ioscm_pkg::IDX_FINE, d);
		check(d, 32'h3F, "fine upper");
		wr(8'h00, 8'h55, 4'h1, ioscm_pkg::RESP_DECERR);
		rd(8'h00, d, ioscm_pkg::RESP_DECERR);
		check(d, 32'h0, "unmapped");
		$display("test trims done");

		for (i = 0; i < 3; i++) begin
			wr(ioscm_pkg::IDX_COARSE, (i == 1) ? 8'h00 : 8'h7F);
			wr(ioscm_pkg::IDX_FINE, (i == 2) ? 8'h00 : 8'h3F);
			gap(0, c);
			gap(0, p);
			check(p, per((i == 1) ? 0 : 127, (i == 2) ? 0 : 63), "osc period");
		end
		wr(ioscm_pkg::IDX_FINE, 8'h3F);
		oscP = per(127, 63);
		$display("test period done");

		// the first pulse after a write may still belong to the old setting
		for (i = 7; i >= 0; i--) begin
			wr(ioscm_pkg::IDX_CTRL, 8'hC0 | 8'(i));
			gap(1, c);
			gap(1, c);
			gap(1, p);
			check(p, oscP << (7 - i), "divider");
		end
		$display("test divider done");

		// software keeps the reserved bit at zero, so only its read value is checked
		wr(ioscm_pkg::IDX_CTRL, 8'hC7);
		rd(ioscm_pkg::IDX_CTRL, d);
		check(d & 32'hEF, 32'hC7, "bit3");
		wr(ioscm_pkg::IDX_CTRL, 8'hE7);
		rd(ioscm_pkg::IDX_CTRL, d);
		check(d & 32'h20, 32'h20, "suspend set");
		cmp0En <= 1'h1;
		cnt(0, 300, c);
		check(c, 0, "halted");
		cmp0En <= 1'h0;
		for (i = 0; i < 5; i++) begin
			wr(ioscm_pkg::IDX_CTRL, 8'hE7);
			@(posedge mclk);
			if (i < 4) portMatch <= 4'h1 << i;
			else cmp0En <= 1'h1;
			if (i == 4) cmp0Out <= 1'h0;
			repeat (2) @(posedge mclk);
			portMatch <= 4'h0;
			cmp0En <= 1'h0;
			cmp0Out <= 1'h1;
			rd(ioscm_pkg::IDX_CTRL, d);
			check(d & 32'h20, 32'h0, "woken");
			cnt(0, 300, c);
			check(c >= 3, 32'h1, "resumed");
		end
		wr(ioscm_pkg::IDX_CTRL, 8'h07);
		cnt(0, 300, c);
		check(c, 0, "disabled");
		rd(ioscm_pkg::IDX_CTRL, d);
		check(d, 32'h07, "not ready");
		wr(ioscm_pkg::IDX_CTRL, 8'hC7);
		waitRdy();
		check(d, 32'hD7, "ready again");
		$display("test suspend done");

		for (j = 0; j < 2; j++) begin
			for (i = 0; i < 8; i++) begin
				mcfg({3'(i), j[0], 1'h0});
				k = (i < 3) ? 2 : i;
				gap(0, c);
				cnt(2, k * oscP, c);
				check(c, (j == 1) ? 8 : 2 * k, "mult rate");
			end
		end
		// x4 scaled by 2/7 is the setting meant to drive a fast core clock
		wr(ioscm_pkg::IDX_SYS_CLOCK_SOURCE_REG, 8'h02);
		gap(0, c);
		@(posedge mclk);
		cnt(1, 7 * oscP, c);
		// four pulses per input tick scaled by 2/7 give 8 over 7 input periods
		check(c, 8, "sys from mult");
		// external source runs well before any multiplier init that uses it
		extOn <= 1'h1;
		for (j = 0; j < 2; j++) begin
			mcfg({3'h0, j[0], 1'h1});
			gap(3, c);
			cnt(2, 200, c);
			check(c, 4 + 4 * j, "ext mult");
		end
		// source code 01 passes the external ticks one cycle later
		wr(ioscm_pkg::IDX_SYS_CLOCK_SOURCE_REG, 8'h01);
		gap(3, c);
		cnt(1, 200, c);
		check(c, 2, "sys from ext");
		$display("test multiplier done");
		results;
	end
endmodule
`default_nettype wire
